//--- verilog/ranging_status_pkg.sv
package ranging_status_pkg;

   // register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_FIX_REV = 8'h02;
   localparam logic [7:0] IDX_COMPILE_REV = 8'h03;
   localparam logic [7:0] IDX_APP_CODE = 8'h04;
   localparam logic [7:0] IDX_MEAS_CODE = 8'h05;
   localparam logic [7:0] IDX_ALG_CODE = 8'h06;
   localparam logic [7:0] IDX_COMMAND = 8'h08;
   localparam logic [7:0] IDX_FLAGS = 8'h09;
   localparam logic [7:0] IDX_ENABLES = 8'h0a;

   // command register values
   localparam logic [7:0] CMD_START_MEASURE = 8'h10;
   localparam logic [7:0] CMD_CLEAR_CODES = 8'h11;

   // flag layout: status-nonzero flag and its enable share one position
   localparam int FLAG_BIT = 6;

   localparam logic [7:0] CODE_SUCCESS = 8'h00;

   // application codes
   localparam logic [7:0] memory_selftest_failure = 8'h01;
   localparam logic [7:0] measurement_stop_failure = 8'h02;
   localparam logic [7:0] sleep_timer_range_failure = 8'h03;
   localparam logic [7:0] unplanned_restart = 8'h04;
   localparam logic [7:0] unprogrammed_trim_warning = 8'h05;

   // measurement codes
   localparam logic [7:0] emitter_safety_failure = 8'h11;
   localparam logic [7:0] breakdown_search_failure = 8'h12;
   localparam logic [7:0] excess_configuration_failure = 8'h15;
   localparam logic [7:0] unconfigured_start_failure = 8'h16;
   localparam logic [7:0] buffer_double_return_failure = 8'h17;
   localparam logic [7:0] converter_lockup_failure = 8'h18;

   // algorithm codes
   localparam logic [7:0] electrical_cal_failure = 8'h21;
   localparam logic [7:0] electrical_cal_missing_buffer = 8'h22;
   localparam logic [7:0] electrical_cal_index_mismatch = 8'h23;

   // wait after remap reset before revisions are valid
   localparam int REMAP_WAIT_US = 6000;
   localparam int CLOCK_MHZ = 100;
   localparam int REMAP_WAIT_CYCLES = REMAP_WAIT_US * CLOCK_MHZ;

   // event strobes from the application, measurement and algorithm engines
   typedef struct packed {
      logic selftest_fail;
      logic stop_fail;
      logic timer_range_fail;
      logic restart;
      logic trim_unprogrammed;
   } app_events_type;

   typedef struct packed {
      logic emitter_fail;
      logic breakdown_fail;
      logic config_excess;
      logic unconfigured_start;
      logic buffer_double_return;
      logic converter_lockup;
   } meas_events_type;

   typedef struct packed {
      logic cal_fail;
      logic cal_missing_buffer;
      logic cal_index_mismatch;
   } alg_events_type;

endpackage

//--- verilog/ranging_app_status_registers.sv
// Operation
// - application code reads 0x00 while no application error
// - unrepairable histogram memory self test fault gives application code 0x01
// - failed measurement stop forces hard shutdown and gives code 0x02
// - sleep timer out of range on wakeup gives application code 0x03
// - unexpected processor or system reset gives application code 0x04
// - unprogrammed fuses give application warning code 0x05
// - measurement code reads 0x00 while measurement machine has no error
// - emitter eye-safety failure gives measurement code 0x11
// - no breakdown voltage found gives measurement code 0x12
// - third configuration attempt gives measurement code 0x15
// - start before configuration gives measurement code 0x16
// - buffer returned twice gives measurement code 0x17
// - converter lockup from spread-spectrum setting gives measurement code 0x18
// - algorithm code reads 0x00 while algorithm has no error
// - electrical calibration failure gives algorithm code 0x21
// - electrical calibration without buffer gives algorithm code 0x22
// - electrical calibration index mismatch gives algorithm code 0x23
// - any nonzero code sets sticky flag; enabled flag pulls interrupt low
// - clear command 0x11 or new measurement start clears all codes
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module ranging_app_status_registers
   import ranging_status_pkg::*;
#(
   parameter logic [7:0] FIX_REVISION = 8'h01, // arbitrary value
   parameter logic [7:0] COMPILE_REVISION = 8'h01, // arbitrary value
   parameter int REMAP_WAIT = REMAP_WAIT_CYCLES
)
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic remap_reset,
   input wire app_events_type app_events,
   input wire meas_events_type meas_events,
   input wire alg_events_type alg_events,
   output logic measure_start,
   output logic measure_hard_stop,
   output logic revisions_valid,
   output logic int_n
);

   logic rst_meta_q;
   logic rst_sync_q;
   logic rst_n;

   // two-stage release of the asynchronous reset
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // word index decode; low two address bits must be zero
   function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
      hit = (addr[1:0] == 2'b00) && (addr[11:2] == {2'b00, idx});
   endfunction

   logic access;
   logic wr_en;
   logic mapped;
   logic clear_cmd;
   logic start_cmd;
   logic [7:0] app_code_q;
   logic [7:0] meas_code_q;
   logic [7:0] alg_code_q;
   logic [7:0] app_code_d;
   logic [7:0] meas_code_d;
   logic [7:0] alg_code_d;
   logic flag_q;
   logic enable_q;
   logic [31:0] prdata_q;
   logic [$clog2(REMAP_WAIT + 1)-1:0] wait_cnt_q;

   // single-cycle access phase: every transfer completes in its first access cycle
   assign access = psel && penable;
   assign wr_en = access && pwrite;
   assign pready = 1'b1;

   always_comb
   begin
      if (hit(paddr, IDX_FIX_REV))
         mapped = 1'b1;
      else if (hit(paddr, IDX_COMPILE_REV))
         mapped = 1'b1;
      else if (hit(paddr, IDX_APP_CODE))
         mapped = 1'b1;
      else if (hit(paddr, IDX_MEAS_CODE))
         mapped = 1'b1;
      else if (hit(paddr, IDX_ALG_CODE))
         mapped = 1'b1;
      else if (hit(paddr, IDX_COMMAND))
         mapped = 1'b1;
      else if (hit(paddr, IDX_FLAGS))
         mapped = 1'b1;
      else if (hit(paddr, IDX_ENABLES))
         mapped = 1'b1;
      else
         mapped = 1'b0;
   end

   // unmapped addresses answer with an error; writes to read-only words are dropped
   assign pslverr = access && !mapped;

   // command decode
   assign clear_cmd = wr_en && hit(paddr, IDX_COMMAND) && (pwdata[7:0] == CMD_CLEAR_CODES);
   assign start_cmd = wr_en && hit(paddr, IDX_COMMAND) && (pwdata[7:0] == CMD_START_MEASURE);
   assign measure_start = start_cmd;

   // hard shutdown of the measurement machine when the stop attempt fails
   assign measure_hard_stop = app_events.stop_fail;

   // application code: lowest code wins among simultaneous events
   always_comb
   begin
      app_code_d = app_code_q;
      if (clear_cmd || start_cmd)
         app_code_d = CODE_SUCCESS;
      if (app_events.trim_unprogrammed)
         app_code_d = unprogrammed_trim_warning;
      if (app_events.restart)
         app_code_d = unplanned_restart;
      if (app_events.timer_range_fail)
         app_code_d = sleep_timer_range_failure;
      if (app_events.stop_fail)
         app_code_d = measurement_stop_failure;
      if (app_events.selftest_fail)
         app_code_d = memory_selftest_failure;
   end

   // measurement code; 0x13 and 0x14 have no source so never appear
   always_comb
   begin
      meas_code_d = meas_code_q;
      if (clear_cmd || start_cmd)
         meas_code_d = CODE_SUCCESS;
      if (meas_events.converter_lockup)
         meas_code_d = converter_lockup_failure;
      if (meas_events.buffer_double_return)
         meas_code_d = buffer_double_return_failure;
      if (meas_events.unconfigured_start)
         meas_code_d = unconfigured_start_failure;
      if (meas_events.config_excess)
         meas_code_d = excess_configuration_failure;
      if (meas_events.breakdown_fail)
         meas_code_d = breakdown_search_failure;
      if (meas_events.emitter_fail)
         meas_code_d = emitter_safety_failure;
   end

   // algorithm code
   always_comb
   begin
      alg_code_d = alg_code_q;
      if (clear_cmd || start_cmd)
         alg_code_d = CODE_SUCCESS;
      if (alg_events.cal_index_mismatch)
         alg_code_d = electrical_cal_index_mismatch;
      if (alg_events.cal_missing_buffer)
         alg_code_d = electrical_cal_missing_buffer;
      if (alg_events.cal_fail)
         alg_code_d = electrical_cal_failure;
   end

   // code registers: success after reset, events override a same-cycle clear
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         app_code_q <= CODE_SUCCESS;
         meas_code_q <= CODE_SUCCESS;
         alg_code_q <= CODE_SUCCESS;
      end
      else
      begin
         app_code_q <= app_code_d;
         meas_code_q <= meas_code_d;
         alg_code_q <= alg_code_d;
      end
   end

   // sticky flag: set on any code turning nonzero, write one clears, set wins
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         flag_q <= 1'b0;
      else if ((app_code_d != CODE_SUCCESS && app_code_d != app_code_q)
            || (meas_code_d != CODE_SUCCESS && meas_code_d != meas_code_q)
            || (alg_code_d != CODE_SUCCESS && alg_code_d != alg_code_q))
         flag_q <= 1'b1;
      else if (wr_en && hit(paddr, IDX_FLAGS) && pwdata[FLAG_BIT])
         flag_q <= 1'b0;
   end

   // interrupt enable bit
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         enable_q <= 1'b0;
      else if (wr_en && hit(paddr, IDX_ENABLES))
         enable_q <= pwdata[FLAG_BIT];
   end

   // interrupt pin is active low and registered
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         int_n <= 1'b1;
      else
         int_n <= !(flag_q && enable_q);
   end

   // remap reset wait; revisions read zero until the wait is over
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         wait_cnt_q <= '0;
      else if (remap_reset)
         wait_cnt_q <= $bits(wait_cnt_q)'(REMAP_WAIT);
      else if (wait_cnt_q != '0)
         wait_cnt_q <= wait_cnt_q - 1'b1;
   end
   assign revisions_valid = (wait_cnt_q == '0);

   // read data is registered during the setup cycle so it is stable in the access phase
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         prdata_q <= '0;
      else if (psel && !penable && !pwrite)
      begin
         prdata_q <= '0;
         if (hit(paddr, IDX_FIX_REV) && revisions_valid)
            prdata_q[7:0] <= FIX_REVISION;
         else if (hit(paddr, IDX_COMPILE_REV) && revisions_valid)
            prdata_q[7:0] <= COMPILE_REVISION;
         else if (hit(paddr, IDX_APP_CODE))
            prdata_q[7:0] <= app_code_q;
         else if (hit(paddr, IDX_MEAS_CODE))
            prdata_q[7:0] <= meas_code_q;
         else if (hit(paddr, IDX_ALG_CODE))
            prdata_q[7:0] <= alg_code_q;
         else if (hit(paddr, IDX_FLAGS))
            prdata_q[FLAG_BIT] <= flag_q;
         else if (hit(paddr, IDX_ENABLES))
            prdata_q[FLAG_BIT] <= enable_q;
      end
   end
   assign prdata = prdata_q;

   // checks
   chk_clear_codes: assert property (@(posedge clock) disable iff (!rst_n)
      (clear_cmd && app_events == '0 && meas_events == '0 && alg_events == '0)
      |=> (app_code_q == CODE_SUCCESS && meas_code_q == CODE_SUCCESS
         && alg_code_q == CODE_SUCCESS))
      else $error("codes not cleared by clear command");

   chk_selftest_code: assert property (@(posedge clock) disable iff (!rst_n)
      app_events.selftest_fail |=> app_code_q == memory_selftest_failure)
      else $error("self test code wrong");

   chk_stop_shutdown: assert property (@(posedge clock) disable iff (!rst_n)
      app_events.stop_fail && !app_events.selftest_fail
      |-> measure_hard_stop ##1 app_code_q == measurement_stop_failure)
      else $error("stop failure handling wrong");

   chk_emitter_code: assert property (@(posedge clock) disable iff (!rst_n)
      meas_events.emitter_fail |=> meas_code_q == emitter_safety_failure)
      else $error("emitter code wrong");

   chk_lockup_code: assert property (@(posedge clock) disable iff (!rst_n)
      $onehot(meas_events) && meas_events.converter_lockup |=> meas_code_q == converter_lockup_failure)
      else $error("lockup code wrong");

   chk_reserved_codes: assert property (@(posedge clock) disable iff (!rst_n)
      meas_code_q != 8'h13 && meas_code_q != 8'h14)
      else $error("reserved measurement code shown");

   chk_cal_code: assert property (@(posedge clock) disable iff (!rst_n)
      alg_events.cal_fail |=> alg_code_q == electrical_cal_failure)
      else $error("calibration code wrong");

   chk_flag_sets: assert property (@(posedge clock) disable iff (!rst_n)
      (alg_events.cal_fail && alg_code_q == CODE_SUCCESS) |=> flag_q ##1 (int_n == !enable_q))
      else $error("nonzero flag or interrupt wrong");

   chk_codes_hold: assert property (@(posedge clock) disable iff (!rst_n)
      (!clear_cmd && !start_cmd && app_events == '0) |=> $stable(app_code_q))
      else $error("application code changed without cause");

   // single events so that priority between codes cannot mask a wrong encoding
   chk_timer_code: assert property (@(posedge clock) disable iff (!rst_n)
      $onehot(app_events) && app_events.timer_range_fail
      |=> app_code_q == sleep_timer_range_failure)
      else $error("timer range code wrong");

   chk_restart_code: assert property (@(posedge clock) disable iff (!rst_n)
      $onehot(app_events) && app_events.restart |=> app_code_q == unplanned_restart)
      else $error("restart code wrong");

   chk_trim_warning: assert property (@(posedge clock) disable iff (!rst_n)
      $onehot(app_events) && app_events.trim_unprogrammed
      |=> app_code_q == unprogrammed_trim_warning)
      else $error("trim warning code wrong");

   chk_breakdown_code: assert property (@(posedge clock) disable iff (!rst_n)
      $onehot(meas_events) && meas_events.breakdown_fail
      |=> meas_code_q == breakdown_search_failure)
      else $error("breakdown code wrong");

   chk_config_code: assert property (@(posedge clock) disable iff (!rst_n)
      $onehot(meas_events) && meas_events.config_excess
      |=> meas_code_q == excess_configuration_failure)
      else $error("configuration count code wrong");

   chk_unconfigured_code: assert property (@(posedge clock) disable iff (!rst_n)
      $onehot(meas_events) && meas_events.unconfigured_start
      |=> meas_code_q == unconfigured_start_failure)
      else $error("unconfigured start code wrong");

   chk_buffer_code: assert property (@(posedge clock) disable iff (!rst_n)
      $onehot(meas_events) && meas_events.buffer_double_return
      |=> meas_code_q == buffer_double_return_failure)
      else $error("buffer return code wrong");

   chk_missing_buffer: assert property (@(posedge clock) disable iff (!rst_n)
      $onehot(alg_events) && alg_events.cal_missing_buffer
      |=> alg_code_q == electrical_cal_missing_buffer)
      else $error("missing buffer code wrong");

   chk_index_mismatch: assert property (@(posedge clock) disable iff (!rst_n)
      $onehot(alg_events) && alg_events.cal_index_mismatch
      |=> alg_code_q == electrical_cal_index_mismatch)
      else $error("index mismatch code wrong");

   chk_start_clears: assert property (@(posedge clock) disable iff (!rst_n)
      (start_cmd && app_events == '0 && meas_events == '0 && alg_events == '0)
      |=> (app_code_q == CODE_SUCCESS && meas_code_q == CODE_SUCCESS
         && alg_code_q == CODE_SUCCESS))
      else $error("codes not cleared by measurement start");

   // a revision read inside the remap wait must not show a half-loaded value
   chk_revision_blank: assert property (@(posedge clock) disable iff (!rst_n)
      (psel && !penable && !pwrite && !revisions_valid && hit(paddr, IDX_FIX_REV))
      |=> prdata == '0)
      else $error("revision visible during remap wait");

   chk_meas_hold: assert property (@(posedge clock) disable iff (!rst_n)
      (!clear_cmd && !start_cmd && meas_events == '0) |=> $stable(meas_code_q))
      else $error("measurement code changed without cause");

   chk_alg_hold: assert property (@(posedge clock) disable iff (!rst_n)
      (!clear_cmd && !start_cmd && alg_events == '0) |=> $stable(alg_code_q))
      else $error("algorithm code changed without cause");

   cov_start_clear: cover property (@(posedge clock) disable iff (!rst_n)
      meas_code_q != CODE_SUCCESS ##1 start_cmd);
   cov_clear: cover property (@(posedge clock) disable iff (!rst_n)
      app_code_q != CODE_SUCCESS ##1 clear_cmd);
   cov_interrupt: cover property (@(posedge clock) disable iff (!rst_n) $fell(int_n));
   cov_revision_read: cover property (@(posedge clock) disable iff (!rst_n)
      revisions_valid && access && hit(paddr, IDX_FIX_REV));

endmodule

//--- testbench/apb_host_model.sv
`timescale 1ns/1ps
module apb_host_model #(
   parameter int REMAP_WAIT = 20
)
(
   input wire logic clock,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // bus idle from time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'hfff;
      pwdata = 32'h5a5a5a5a;
   end

   // one transfer: setup cycle, then access until pready is seen at an edge
   task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      // no assumed latency: only the bench watchdog ends a hung wait
      do
      begin
         @(posedge clock);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released data is inverted so a stale value never looks valid
      pwdata <= ~wd;
   endtask

   // revisions are untrusted until the post-remap wait has run out
   task automatic remap_wait();
      repeat (REMAP_WAIT + 2) @(posedge clock);
   endtask
endmodule

//--- testbench/ranging_app_status_registers_test.sv
`timescale 1ns/1ps
module ranging_app_status_registers_test;
   import ranging_status_pkg::*;
   localparam int WAIT_SIM = 20;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic remap_reset = 1'b0;
   logic [13:0] ev = 14'h0;
   logic psel, penable, pwrite, pready, pslverr;
   logic measure_start, measure_hard_stop, revisions_valid, int_n, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   // distinct revision values so a swapped decode is caught; values are arbitrary
   localparam logic [7:0] FIX_SIM = 8'h2a;
   localparam logic [7:0] COMPILE_SIM = 8'h4b;
   int bad_count = 0;
   int total_checks = 0;
   int starts = 0;
   // expected code per event bit, application msb first, then measurement, then algorithm
   logic [7:0] codes [14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h11, 8'h12,
                              8'h15, 8'h16, 8'h17, 8'h18, 8'h21, 8'h22, 8'h23};

   always #5 clock = ~clock;

   ranging_app_status_registers #(
      .FIX_REVISION(FIX_SIM),
      .COMPILE_REVISION(COMPILE_SIM),
      .REMAP_WAIT(WAIT_SIM)
   ) u_ranging_app_status_registers (
      .clock(clock),
      .arst_n(arst_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .remap_reset(remap_reset),
      .app_events(app_events_type'(ev[13:9])),
      .meas_events(meas_events_type'(ev[8:3])),
      .alg_events(alg_events_type'(ev[2:0])),
      .measure_start(measure_start),
      .measure_hard_stop(measure_hard_stop),
      .revisions_valid(revisions_valid),
      .int_n(int_n)
   );

   apb_host_model #(
      .REMAP_WAIT(WAIT_SIM)
   ) u_apb_host_model (
      .clock(clock),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // read a mapped word and compare; a mapped word never errors
   task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
      u_apb_host_model.xfer(1'b0, addr, 32'h0, rd, err);
      chk(rd, exp);
      chk({31'h0, err}, 32'h0);
   endtask

   task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
      u_apb_host_model.xfer(1'b1, addr, wd, rd, err);
   endtask

   // one-cycle event strobe; the hard stop follows the stop failure strobe
   task automatic pulse(input logic [13:0] m);
      @(posedge clock);
      ev <= m;
      #1;
      chk({31'h0, measure_hard_stop}, {31'h0, m[12]});
      @(posedge clock);
      ev <= 14'h0;
   endtask

   // count measurement start strobes; inputs move by nonblocking assignment after the edge
   always @(posedge clock)
   begin
      if (measure_start === 1'b1)
         starts++;
   end

   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // watchdog: the sequence needs well under two thousand cycles
   initial
   begin
      repeat (20000) @(posedge clock);
      bad_count++;
      print_verdict();
   end

   initial
   begin
      logic [11:0] a;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      chk({31'h0, int_n}, 32'h1);
      for (int i = 0; i < 3; i++)
         rd_chk(12'h10 + 12'(4 * i), 32'h0);
      rd_chk(12'h24, 32'h0);
      wr(12'h08, 32'hff);
      rd_chk(12'h08, {24'h0, FIX_SIM});
      rd_chk(12'h0c, {24'h0, COMPILE_SIM});
      // revisions blank during the remap wait, then valid again
      @(posedge clock);
      remap_reset <= 1'b1;
      @(posedge clock);
      remap_reset <= 1'b0;
      rd_chk(12'h08, 32'h0);
      chk({31'h0, revisions_valid}, 32'h0);
      u_apb_host_model.remap_wait();
      chk({31'h0, revisions_valid}, 32'h1);
      rd_chk(12'h0c, {24'h0, COMPILE_SIM});
      rd_chk(12'h08, {24'h0, FIX_SIM});
      wr(12'h28, 32'h40);
      rd_chk(12'h28, 32'h40);
      // every event code, cleared alternately by clear and by start
      for (int i = 0; i < 14; i++)
      begin
         a = (i < 5) ? 12'h10 : ((i < 11) ? 12'h14 : 12'h18);
         pulse(14'h2000 >> i);
         rd_chk(a, {24'h0, codes[i]});
         chk({31'h0, int_n}, 32'h0);
         wr(a, 32'h00);
         rd_chk(a, {24'h0, codes[i]});
         wr(12'h20, (i % 2) ? 32'h10 : 32'h11);
         wr(12'h24, 32'h40);
         rd_chk(a, 32'h0);
         chk({31'h0, int_n}, 32'h1);
      end
      // seven start commands went out, each a single access-phase strobe
      chk(starts, 32'h7);
      // masked flag still sticks but leaves the interrupt line high
      wr(12'h28, 32'h0);
      pulse(14'h0004);
      rd_chk(12'h18, 32'h21);
      chk({31'h0, int_n}, 32'h1);
      rd_chk(12'h24, 32'h40);
      // simultaneous application events: lowest code wins
      wr(12'h20, 32'h11);
      pulse(14'h2400);
      rd_chk(12'h10, 32'h01);
      u_apb_host_model.xfer(1'b0, 12'h3fc, 32'h0, rd, err);
      chk({31'h0, err}, 32'h1);
      print_verdict();
   end
endmodule
